// [src/slot_cfg_pkg.sv]
// Package: offsets, field layout and types of the slot configuration registers
package slot_cfg_pkg;
   localparam logic [7:0] SLOT_ONE_CONFIG_OFFSET = 8'h10;
   localparam logic [7:0] SLOT_TWO_CONFIG_OFFSET = 8'h14;
   localparam int AVG_LSB = 24;
   localparam int DELAY_LSB = 16;
   localparam int INPUT_LSB = 8;
   localparam int WINDOW_BIT = 1;
   localparam int ACTIVE_BIT = 0;
   localparam logic [31:0] WRITABLE_MASK = 32'h0707_0F03;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam int NUM_SLOTS = 2;
   localparam logic [3:0] INPUT_TEMP = 4'h8;
   localparam logic [3:0] INPUT_SUPPLY = 4'h9;
   localparam logic [3:0] INPUT_GROUND = 4'hA;
   localparam logic [3:0] INPUT_BATTERY = 4'hC;

   typedef enum logic [1:0] {
      SRC_EXTERNAL,
      SRC_INTERNAL,
      SRC_UNUSED
   } input_kind_t;

   typedef struct packed {
      logic [7:0] average_count;
      logic [7:0] hold_cycles;
      logic [3:0] input_select;
      logic [7:0] external_onehot;
      logic temp_select;
      logic supply_select;
      logic ground_select;
      logic battery_select;
      logic window_check_on;
      logic active;
   } slot_ctrl_t;
endpackage

// [src/slot_cfg_word.sv]
// One slot configuration word with write masking and decoded controls
`timescale 1ns/1ps
module slot_cfg_word
   import slot_cfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic write_in,
   input wire logic [31:0] wdata_in,
   output logic [31:0] value_out,
   output slot_ctrl_t ctrl_out
);
   logic [31:0] cfg_reg;
   logic [31:0] cfg_next;
   slot_ctrl_t ctrl_next;
   wire logic [2:0] avg_code = cfg_next[AVG_LSB +: 3];
   wire logic [2:0] delay_code = cfg_next[DELAY_LSB +: 3];
   wire logic [3:0] sel_code = cfg_next[INPUT_LSB +: 4];

   // Reserved bits never store
   assign cfg_next = write_in ? (wdata_in & WRITABLE_MASK) : cfg_reg; // see RL10

   always_comb begin
      ctrl_next = '0;
      ctrl_next.average_count = 8'(1) << avg_code; // see RL1
      ctrl_next.hold_cycles = 8'(1) << delay_code; // see RL2
      ctrl_next.input_select = sel_code;
      if (!sel_code[3]) begin
         ctrl_next.external_onehot = 8'(1) << sel_code[2:0]; // see RL5
      end
      ctrl_next.temp_select = (sel_code == INPUT_TEMP); // see RL5
      ctrl_next.supply_select = (sel_code == INPUT_SUPPLY);
      ctrl_next.ground_select = (sel_code == INPUT_GROUND);
      ctrl_next.battery_select = (sel_code == INPUT_BATTERY);
      ctrl_next.window_check_on = cfg_next[WINDOW_BIT]; // see RL6
      ctrl_next.active = cfg_next[ACTIVE_BIT]; // see RL7
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_reg <= CONFIG_RESET; // see RL10
         ctrl_out <= '0;
      end else begin
         cfg_reg <= cfg_next;
         ctrl_out <= ctrl_next;
      end
   end

   assign value_out = cfg_reg;
endmodule

// [src/adc_slot_config_regs.sv]
// APB register block holding the slot 1 and slot 2 scan configurations
//
// Summary of operation
// RL1: Bits 26:24 average two-to-the-n measurements
// RL2: Bits 18:16 hold two-to-the-n ADC clocks
// RL3: Software keeps hold time under fifty microseconds
// RL4: Slow clock: software limits hold to 64
// RL5: Bits 11:8 pick pin, temperature, supply, ground, battery
// RL6: Bit 1 turns on window compare
// RL7: Bit 0 includes slot in scans
// RL8: Slot two has own identical register
// RL9: Software changes slots only while converter disabled
// RL10: Reserved bits read zero; reset clears all
`timescale 1ns/1ps
module adc_slot_config_regs
   import slot_cfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output slot_ctrl_t slot_one_ctrl_out,
   output slot_ctrl_t slot_two_ctrl_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Bus phase of the present cycle

   typedef enum {
      PHASE_IDLE,
      PHASE_SETUP,
      PHASE_ACCESS
   } bus_phase_t;

   function automatic bus_phase_t phase_of(input logic sel, input logic enable);
      bus_phase_t phase;
      phase = PHASE_IDLE;
      case ({sel, enable})
         2'h2: begin
            phase = PHASE_SETUP;
         end
         2'h3: begin
            phase = PHASE_ACCESS;
         end
         default: begin
            phase = PHASE_IDLE;
         end
      endcase
      return phase;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic [7:0] offset_of(input int slot);
      logic [7:0] offset;
      offset = SLOT_ONE_CONFIG_OFFSET;
      case (slot)
         0: begin
            offset = SLOT_ONE_CONFIG_OFFSET;
         end
         default: begin
            offset = SLOT_TWO_CONFIG_OFFSET;
         end
      endcase
      return offset;
   endfunction

   // One bit per slot; all clear for an unmapped address
   function automatic logic [NUM_SLOTS-1:0] decode_slots(input logic [7:0] addr);
      logic [NUM_SLOTS-1:0] hits;
      hits = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         hits[s] = (addr == offset_of(s));
      end
      return hits;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read-back word

   // Rebuilt from the stored fields, so reserved bits cannot leak out
   function automatic logic [31:0] pack_fields(
         input logic [2:0] average,
         input logic [2:0] delay,
         input logic [3:0] select,
         input logic window,
         input logic active
      );
      logic [31:0] word;
      word = CONFIG_RESET;
      word[AVG_LSB +: 3] = average;
      word[DELAY_LSB +: 3] = delay;
      word[INPUT_LSB +: 4] = select;
      word[WINDOW_BIT] = window;
      word[ACTIVE_BIT] = active;
      return word;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   bus_phase_t phase_now;
   logic [NUM_SLOTS-1:0] slot_hit;
   logic setup_phase;
   logic access_done;
   logic mapped;
   logic [NUM_SLOTS-1:0] write_hit;

   assign phase_now = phase_of(psel_in, penable_in);
   assign slot_hit = decode_slots(paddr_in);
   assign setup_phase = (phase_now == PHASE_SETUP);
   // Writes land only at the edge that completes the access
   assign access_done = (phase_now == PHASE_ACCESS) && pready_out;
   assign mapped = |slot_hit;
   assign write_hit = {NUM_SLOTS{access_done && pwrite_in}} & slot_hit; // see RL8

   ////////////////////////////////////////////////////////////////////////////
   // Slot storage: each slot is an independent word

   logic [31:0] word_value [NUM_SLOTS];
   slot_ctrl_t word_ctrl [NUM_SLOTS];

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : slot_words
         slot_cfg_word u_word (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .write_in(write_hit[g]), // see RL8
            .wdata_in(pwdata_in),
            .value_out(word_value[g]),
            .ctrl_out(word_ctrl[g])
         );
      end
   endgenerate

   assign slot_one_ctrl_out = word_ctrl[0];
   assign slot_two_ctrl_out = word_ctrl[1];

   ////////////////////////////////////////////////////////////////////////////
   // Field views of the two slot words

   logic [2:0] slot_one_average_count;
   logic [2:0] slot_one_sample_delay;
   logic [3:0] slot_one_input_select;
   logic slot_one_window_check_on;
   logic slot_one_active;
   logic [2:0] slot_two_average_count;
   logic [2:0] slot_two_sample_delay;
   logic [3:0] slot_two_input_select;
   logic slot_two_window_check_on;
   logic slot_two_active;
   logic [31:0] slot_one_config;
   logic [31:0] slot_two_config;

   assign slot_one_average_count = word_value[0][AVG_LSB +: 3];
   assign slot_one_sample_delay = word_value[0][DELAY_LSB +: 3];
   assign slot_one_input_select = word_value[0][INPUT_LSB +: 4];
   assign slot_one_window_check_on = word_value[0][WINDOW_BIT];
   assign slot_one_active = word_value[0][ACTIVE_BIT];
   assign slot_two_average_count = word_value[1][AVG_LSB +: 3];
   assign slot_two_sample_delay = word_value[1][DELAY_LSB +: 3];
   assign slot_two_input_select = word_value[1][INPUT_LSB +: 4];
   assign slot_two_window_check_on = word_value[1][WINDOW_BIT];
   assign slot_two_active = word_value[1][ACTIVE_BIT];

   assign slot_one_config = pack_fields(
      slot_one_average_count,
      slot_one_sample_delay,
      slot_one_input_select,
      slot_one_window_check_on,
      slot_one_active
   ); // see RL10
   assign slot_two_config = pack_fields(
      slot_two_average_count,
      slot_two_sample_delay,
      slot_two_input_select,
      slot_two_window_check_on,
      slot_two_active
   ); // see RL10

   ////////////////////////////////////////////////////////////////////////////
   // Read selection

   logic [31:0] readback [NUM_SLOTS];
   logic [31:0] read_terms [NUM_SLOTS+1];
   logic [31:0] read_mux;

   assign readback[0] = slot_one_config;
   assign readback[1] = slot_two_config;
   assign read_terms[0] = 32'h0000_0000;

   // Unmapped addresses fall through to zero
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : read_chain
         assign read_terms[g+1] = read_terms[g] | (slot_hit[g] ? readback[g] : 32'h0000_0000);
      end
   endgenerate

   assign read_mux = read_terms[NUM_SLOTS];

   ////////////////////////////////////////////////////////////////////////////
   // Answer: no wait state, ready raised in the first access cycle

   logic [31:0] prdata_next;
   logic pslverr_next;

   // Latched in setup, while the address is already stable
   assign prdata_next = (setup_phase && !pwrite_in) ? read_mux : 32'h0000_0000; // see RL10
   assign pslverr_next = setup_phase && !mapped;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= setup_phase;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else begin
         prdata_out <= prdata_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= pslverr_next;
      end
   end
endmodule

// [tb/slot_cfg_monitor.sv]
// Checker for slot register decode and bus answers
`timescale 1ns/1ps
module slot_cfg_monitor
   import slot_cfg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire slot_ctrl_t slot_one_ctrl_out,
   input wire slot_ctrl_t slot_two_ctrl_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_wr(logic [7:0] a);
      psel_in && !penable_in ##1 penable_in && pready_out && pwrite_in && paddr_in == a;
   endsequence
   AST_AVG: assert property (s_wr(8'h10) |=> slot_one_ctrl_out.average_count ==
      8'(1 << $past(pwdata_in[26:24]))) else $error("average count wrong");
   AST_HOLD: assert property (s_wr(8'h10) |=> slot_one_ctrl_out.hold_cycles ==
      8'(1 << $past(pwdata_in[18:16]))) else $error("hold cycles wrong");
   AST_SEL: assert property (s_wr(8'h14) |=> slot_two_ctrl_out.ground_select ==
      ($past(pwdata_in[11:8]) == 4'hA)) else $error("input select wrong");
   AST_WIN: assert property (s_wr(8'h10) |=> slot_one_ctrl_out.window_check_on ==
      $past(pwdata_in[1])) else $error("window enable wrong");
   AST_ACT: assert property (s_wr(8'h14) |=> slot_two_ctrl_out.active ==
      $past(pwdata_in[0])) else $error("slot active wrong");
   AST_IND: assert property (s_wr(8'h14) |=> $stable(slot_one_ctrl_out))
      else $error("slot one disturbed");
   AST_RSV: assert property (pready_out && !pwrite_in |->
      (prdata_out & ~WRITABLE_MASK) == 32'h0000_0000) else $error("reserved bits set");
   AST_RST: assert property ($fell(rst_in) |-> slot_one_ctrl_out == '0 &&
      slot_two_ctrl_out == '0) else $error("reset state wrong");
endmodule
bind adc_slot_config_regs slot_cfg_monitor mon (.*);

// [tb/tb.sv]
// Bench for the slot configuration registers
`timescale 1ns/1ps
module tb
   import slot_cfg_pkg::*;
;
   logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, e;
   logic [7:0] paddr_in = 0, a;
   logic [31:0] pwdata_in = 0, prdata_out, d, r;
   logic pready_out, pslverr_out;
   slot_ctrl_t c1, c2;
   logic [31:0] m [2] = '{0, 0};
   int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 32'h6d27;
   adc_slot_config_regs uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .slot_one_ctrl_out(c1), .slot_two_ctrl_out(c2));
   initial forever #2.5 clk_in = ~clk_in;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_in) if (++cyc > 2000) begin
      n_mismatch++;
      tally_and_finish;
   end
   task automatic chk(input logic [35:0] s, input logic [35:0] x);
      total_checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, s, x);
      end
   endtask
   // Leaves psel up so transfers run back to back
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel_in <= 1;
      penable_in <= 0;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      r = prdata_out;
      e = pslverr_out;
   endtask
   function automatic slot_ctrl_t dec(input logic [31:0] v);
      dec = '0;
      dec.average_count = 8'(1) << v[26:24];
      dec.hold_cycles = 8'(1) << v[18:16];
      dec.input_select = v[11:8];
      if (!v[11]) dec.external_onehot = 8'(1) << v[10:8];
      dec.temp_select = v[11:8] == 4'h8;
      dec.supply_select = v[11:8] == 4'h9;
      dec.ground_select = v[11:8] == 4'hA;
      dec.battery_select = v[11:8] == 4'hC;
      dec.window_check_on = v[1];
      dec.active = v[0];
   endfunction
   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 0;
      chk(c1, '0);
      chk(c2, '0);
      for (int i = 0; i < 40; i++) begin
         a = (i % 5 == 4) ? 8'h18 : (i[0] ? 8'h14 : 8'h10);
         d = $random(seed);
         d[11:8] = i[4:1];
         // Fast converter clock first: even 128 hold clocks stay short
         if (i >= 20 && d[18:16] == 3'h7) d[18:16] = 3'h6;
         xfer(1, a, d); // Converter never enabled here
         if (a != 8'h18) m[a[2]] = d & WRITABLE_MASK;
         chk(e, a == 8'h18);
         xfer(0, a, $random(seed));
         chk(r, a == 8'h18 ? 0 : m[a[2]]);
         chk(e, a == 8'h18);
         chk(c1, dec(m[0]));
         chk(c2, dec(m[1]));
      end
      psel_in <= 0;
      penable_in <= 0;
      rst_in <= 1;
      repeat (2) @(posedge clk_in);
      rst_in <= 0;
      m[0] = 0;
      m[1] = 0;
      @(posedge clk_in);
      chk(c1, '0);
      chk(c2, '0);
      for (int j = 0; j < 2; j++) begin
         xfer(0, j ? 8'h14 : 8'h10, 0);
         chk(r, m[j]);
         chk(e, 0);
      end
      chk(c1, dec(m[0]));
      chk(c2, dec(m[1]));
      psel_in <= 0;
      penable_in <= 0;
      tally_and_finish;
   end
endmodule
